// >>> fspc_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Core model issuing store and load instructions
// ****************************************************************
module fspc_cpu_model (
    input wire logic mclk_i, // CPU clock
    output logic spm_o, // Store instruction
    output logic lpm_o, // Load instruction
    output logic [15:0] z_o, // Z pointer
    output logic [15:0] r_word_o, // R1:R0 word
    output logic [14:0] pc_o // Executing word address
);
    initial begin
        spm_o = 1'b0;
        lpm_o = 1'b0;
        z_o = 16'h0000;
        r_word_o = 16'h0000;
        pc_o = 15'h0000;
    end

    // The caller keeps the code address in the boot section while an
    // operation runs, so nothing is fetched from a blocked section.
    task automatic issue(input logic ld, input logic [15:0] z,
        input logic [15:0] r, input logic [14:0] pc, input int d);
        repeat (d) @(posedge mclk_i);
        z_o <= z;
        r_word_o <= r;
        pc_o <= pc;
        if (ld)
            lpm_o <= 1'b1;
        else
            spm_o <= 1'b1;
        @(posedge mclk_i);
        spm_o <= 1'b0;
        lpm_o <= 1'b0;
        // Stale operands are inverted so a late sample cannot pass.
        z_o <= ~z;
        r_word_o <= ~r;
        #1;
    endtask
endmodule // fspc_cpu_model

`default_nettype wire

// >>> fspc_ctrl.sv
// Function
// - Ready interrupt when enabled, idle, not busy.
// - Busy flag reads zero without read-while-write.
// - Unused bit five always reads zero.
// - Read-enable write during fill clears buffer.
// - Armed load returns lock or fuse byte.
// - Armed store writes buffer to page.
// - Write bit clears on finish or timeout.
// - CPU halted throughout page write.
// - Armed store erases addressed page.
// - Erase bit clears on finish or timeout.
// - Enable alone arms buffer fill store.
// - Enable clears after store, timeout, operation.
// - Only five command patterns take effect.
// - Programming refused outside boot section.
// - Boot code may program any page.
// - Fuses size sections, separate lock sets.
// - Readable-section erase runs; page write or halting section stalls.
// - Boot section lies inside halting section.
// - Busy flag set until software re-enables.
// - Z pointer picks lock or fuse byte.
`timescale 1ns/1ns
`default_nettype none
`include "fspc_params.svh"

module fspc_ctrl #(
    parameter int PAGE_WORDS = 32,
    parameter int HALTING_WRITE_SECTION_PAGES = 32,
    parameter bit RWW_SUPPORT = 1'b1,
    parameter int PROG_CYCLES =
        (`FSPC_PROG_TIME_NS + `FSPC_CLK_PERIOD_NS - 1) / `FSPC_CLK_PERIOD_NS
) (
    input wire logic mclk_i, // 10 MHz clock
    input wire logic rst_i, // Asynchronous reset, active high
    input wire logic [7:0] addr_i, // Register address
    input wire logic [7:0] wdata_i, // Register write data
    input wire logic wr_i, // Register write strobe
    input wire logic rd_i, // Register read strobe
    output logic [7:0] rdata_o, // Read data, cycle after rd_i
    input wire logic spm_i, // Store instruction executes
    input wire logic lpm_i, // Load instruction executes
    input wire logic [15:0] z_i, // Z pointer, byte address
    input wire logic [15:0] r_word_i, // R1:R0 word
    input wire logic [14:0] pc_i, // Word address of executing code
    input wire logic gie_i, // Global interrupt flag
    input wire logic eeprom_busy_i, // EEPROM write in progress
    input wire logic [5:0] lock_bits_i, // Lock bits, 0 = programmed
    input wire logic [7:0] fuse_low_i, // Fuse low byte
    input wire logic [7:0] fuse_high_i, // Fuse high byte
    input wire logic [7:0] fuse_ext_i, // Extended fuse byte
    input wire logic [1:0] boot_size_fuses_i, // Boot section size code
    input wire logic [$clog2(PAGE_WORDS)-1:0] buf_rd_addr_i, // Buffer
    output logic [15:0] buf_rd_data_o, // Buffer word, one cycle later
    output logic lpm_valid_o, // Lock/fuse byte replaces load
    output logic [7:0] lpm_data_o, // Lock/fuse byte
    output logic stall_o, // Halt the CPU
    output logic rw_blocked_o, // Readable section is blocked
    output logic irq_o, // Ready interrupt request
    output logic flash_erase_o, // Start page erase, one pulse
    output logic flash_write_o, // Start page write, one pulse
    output logic [14-$clog2(PAGE_WORDS):0] flash_page_o // Target page
);

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int WB = $clog2(PAGE_WORDS);
    localparam int PG_W = 15 - WB;
    localparam int NPAGES = 1 << PG_W;
    localparam int CW = $clog2(PROG_CYCLES + 1);
    // A literal cannot be bit-selected, so the reset value gets a name.
    localparam logic [7:0] CSR_RST = `FSPC_CSR_RESET;

    if (PAGE_WORDS < 2 || (1 << WB) != PAGE_WORDS || WB > 8) begin : g_pw
        $error("PAGE_WORDS must be a power of two from 2 to 256.");
    end
    // The boot section must never reach outside the halting section.
    if (`FSPC_BOOT_PG_MAX > HALTING_WRITE_SECTION_PAGES || HALTING_WRITE_SECTION_PAGES > NPAGES)
    begin : g_halting_write_section
        $error("Halting section must hold the largest boot section.");
    end
    if (PROG_CYCLES < 2) begin : g_pc
        $error("PROG_CYCLES must be at least two.");
    end

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic logic pattern_ok(input logic [4:0] p);
        pattern_ok = (p == `FSPC_PAT_FILL) || (p == `FSPC_PAT_ERS) ||
                     (p == `FSPC_PAT_WRT) || (p == `FSPC_PAT_LFR) ||
                     (p == `FSPC_PAT_RRE);
    endfunction

    function automatic logic [PG_W-1:0] boot_start(input logic [1:0] s);
        int n;
        n = `FSPC_BOOT_PG_0;
        case (s)
            2'h0: n = `FSPC_BOOT_PG_0;
            2'h1: n = `FSPC_BOOT_PG_1;
            2'h2: n = `FSPC_BOOT_PG_2;
            default: n = `FSPC_BOOT_PG_3;
        endcase
        boot_start = PG_W'(NPAGES - n);
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    fspc_pkg::fspc_state_t state;
    fspc_pkg::fspc_state_t next_state;
    logic csr_ie;
    logic [4:0] csr_cmd;
    logic rw_busy;
    logic fill_active;
    logic [2:0] arm_age;
    logic op_write;
    logic [CW-1:0] prog_cnt;
    logic [15:0] page_buf [PAGE_WORDS];

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire reg_hit = (addr_i == `FSPC_REG_CSR);
    wire wr_csr = wr_i & reg_hit;
    wire rd_csr = rd_i & reg_hit;
    wire st_idle = (state == fspc_pkg::FSPC_IDLE);
    wire st_armed = (state == fspc_pkg::FSPC_ARMED);
    wire st_busy = (state == fspc_pkg::FSPC_BUSY);

    // An EEPROM write blocks arming, so no command is accepted under it.
    wire cmd_accept = wr_csr & st_idle & ~eeprom_busy_i &
                      pattern_ok(wdata_i[4:0]);

    wire cmd_fill = (csr_cmd == `FSPC_PAT_FILL);
    wire cmd_ers = (csr_cmd == `FSPC_PAT_ERS);
    wire cmd_wrt = (csr_cmd == `FSPC_PAT_WRT);
    wire cmd_lfr = (csr_cmd == `FSPC_PAT_LFR);
    wire cmd_rre = (csr_cmd == `FSPC_PAT_RRE);

    wire spm_in_window = st_armed & (arm_age <= `FSPC_SPM_WINDOW);
    wire spm_ok = spm_in_window & spm_i;
    wire lpm_ok = st_armed & cmd_lfr & lpm_i &
                  (arm_age <= `FSPC_LPM_WINDOW);
    wire arm_expire = st_armed & ~spm_i & ~lpm_ok &
                      (arm_age == `FSPC_SPM_WINDOW);

    wire [PG_W-1:0] pc_page = pc_i[14:WB];
    wire [PG_W-1:0] z_page = z_i[15:WB+1];
    wire [PG_W-1:0] boot_first = boot_start(boot_size_fuses_i);
    wire [PG_W-1:0] halting_write_section_first = PG_W'(NPAGES - HALTING_WRITE_SECTION_PAGES);

    wire in_boot = (pc_page >= boot_first);
    wire target_boot = (z_page >= boot_first);
    wire target_halting_write_section = (z_page >= halting_write_section_first);
    // Each section answers only to its own lock pair.
    wire lock_ok = target_boot ? lock_bits_i[`FSPC_BLB11] :
                                 lock_bits_i[`FSPC_BLB01];
    // Any page may be the target, boot pages included.
    wire prog_ok = in_boot & lock_ok;

    wire start_op = spm_ok & (cmd_ers | cmd_wrt) & prog_ok;
    wire fill_do = spm_ok & cmd_fill & in_boot;
    wire rre_do = spm_ok & cmd_rre & in_boot;
    wire prog_done = st_busy & (prog_cnt == CW'(1));

    // Without read-while-write every programming halts the core.
    wire halt_op = ~RWW_SUPPORT | target_halting_write_section | cmd_wrt;

    // Clearing the buffer while it is being filled loses its data.
    wire buf_clear = (wr_csr & wdata_i[`FSPC_BIT_RRE] & fill_active &
                      ~st_busy) | (prog_done & op_write);

    wire [WB-1:0] fill_idx = z_i[WB:1];

    wire rw_flag = RWW_SUPPORT ? rw_busy : 1'b0;

    wire [7:0] csr_view = {csr_ie, rw_flag, 1'b0, csr_cmd};

    wire [7:0] lf_byte = (z_i[1:0] == `FSPC_ZSEL_LOCK) ? {2'h3, lock_bits_i} :
                         (z_i[1:0] == `FSPC_ZSEL_FHI) ? fuse_high_i :
                         (z_i[1:0] == `FSPC_ZSEL_FEXT) ? fuse_ext_i :
                         fuse_low_i;

    // Ready while enable is clear and nothing is programming.
    wire next_irq = csr_ie & gie_i & st_idle & ~cmd_accept &
                    ~eeprom_busy_i;

    wire next_stall = (start_op & halt_op) |
                      (stall_o & st_busy & ~prog_done);

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        next_state = state;
        case (state)
            fspc_pkg::FSPC_IDLE: begin
                if (cmd_accept) begin
                    next_state = fspc_pkg::FSPC_ARMED;
                end
            end
            fspc_pkg::FSPC_ARMED: begin
                if (start_op) begin
                    next_state = fspc_pkg::FSPC_BUSY;
                end else if (spm_ok | lpm_ok | arm_expire) begin
                    next_state = fspc_pkg::FSPC_IDLE;
                end
            end
            fspc_pkg::FSPC_BUSY: begin
                if (prog_done) begin
                    next_state = fspc_pkg::FSPC_IDLE;
                end
            end
            default: begin
                next_state = fspc_pkg::FSPC_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= fspc_pkg::FSPC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Control and status register
    // ****************************************************************
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            csr_ie <= CSR_RST[`FSPC_BIT_IE];
        end else if (wr_csr) begin
            csr_ie <= wdata_i[`FSPC_BIT_IE];
        end
    end

    // Command bits stay set through erase or write, else drop at the end.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            csr_cmd <= CSR_RST[4:0];
        end else if (cmd_accept) begin
            csr_cmd <= wdata_i[4:0];
        end else if (next_state == fspc_pkg::FSPC_IDLE) begin
            csr_cmd <= CSR_RST[4:0];
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            arm_age <= `FSPC_AGE_START;
        end else if (cmd_accept) begin
            arm_age <= `FSPC_AGE_START;
        end else if (st_armed) begin
            arm_age <= arm_age + `FSPC_AGE_START;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= `FSPC_CSR_RESET;
        end else begin
            rdata_o <= rd_csr ? csr_view : `FSPC_CSR_RESET;
        end
    end

    // ****************************************************************
    // Readable-section busy flag
    // ****************************************************************
    // Software must re-enable before touching the blocked section.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rw_busy <= 1'b0;
        end else if (start_op & ~target_halting_write_section) begin
            rw_busy <= 1'b1;
        end else if (rre_do) begin
            rw_busy <= 1'b0;
        end
    end

    // ****************************************************************
    // Programming timer and flash strobes
    // ****************************************************************
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            prog_cnt <= '0;
        end else if (start_op) begin
            prog_cnt <= CW'(PROG_CYCLES);
        end else if (st_busy) begin
            prog_cnt <= prog_cnt - CW'(1);
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            op_write <= 1'b0;
            flash_page_o <= '0;
        end else if (start_op) begin
            op_write <= cmd_wrt;
            flash_page_o <= z_page;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            flash_erase_o <= 1'b0;
            flash_write_o <= 1'b0;
        end else begin
            flash_erase_o <= start_op & cmd_ers;
            flash_write_o <= start_op & cmd_wrt;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            stall_o <= 1'b0;
        end else begin
            stall_o <= next_stall;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rw_blocked_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            rw_blocked_o <= rw_flag;
            irq_o <= next_irq;
        end
    end

    // ****************************************************************
    // Lock and fuse read
    // ****************************************************************
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            lpm_valid_o <= 1'b0;
            lpm_data_o <= 8'h00;
        end else begin
            lpm_valid_o <= lpm_ok;
            lpm_data_o <= lpm_ok ? lf_byte : 8'h00;
        end
    end

    // ****************************************************************
    // Temporary page buffer
    // ****************************************************************
    // The store data of erase and write commands never reaches the buffer.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            fill_active <= 1'b0;
        end else if (buf_clear) begin
            fill_active <= 1'b0;
        end else if (fill_do) begin
            fill_active <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < PAGE_WORDS; i++) begin
                page_buf[i] <= `FSPC_ERASED_WORD;
            end
        end else if (buf_clear) begin
            for (int i = 0; i < PAGE_WORDS; i++) begin
                page_buf[i] <= `FSPC_ERASED_WORD;
            end
        end else if (fill_do) begin
            page_buf[fill_idx] <= r_word_i;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            buf_rd_data_o <= `FSPC_ERASED_WORD;
        end else begin
            buf_rd_data_o <= page_buf[buf_rd_addr_i];
        end
    end

endmodule // fspc_ctrl

`default_nettype wire

// >>> fspc_ctrl_monitor.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Port checks for the self-program control block
// ****************************************************************
module fspc_ctrl_monitor #(
    parameter int PROG_CYCLES = 8
) (
    input wire logic mclk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic [7:0] addr_i, // Register address
    input wire logic rd_i, // Read strobe
    input wire logic [7:0] rdata_o, // Read data
    input wire logic spm_i, // Store instruction
    input wire logic lpm_i, // Load instruction
    input wire logic [15:0] z_i, // Z pointer
    input wire logic gie_i, // Global interrupt flag
    input wire logic eeprom_busy_i, // EEPROM busy
    input wire logic [7:0] fuse_low_i, // Fuse low byte
    input wire logic lpm_valid_o, // Lock/fuse byte valid
    input wire logic [7:0] lpm_data_o, // Lock/fuse byte
    input wire logic stall_o, // CPU halt
    input wire logic irq_o, // Ready interrupt
    input wire logic flash_erase_o, // Erase start
    input wire logic flash_write_o // Write start
);
    int unsigned stall_cnt;

    // The halt length is counted here since it is far too long to unroll.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i)
            stall_cnt <= 0;
        else
            stall_cnt <= stall_o ? stall_cnt + 1 : 0;
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_irq_gated: assert property ((eeprom_busy_i || !gie_i) |=> !irq_o)
        else $error("interrupt raised while gated");
    a_irq_busy: assert property (stall_o |-> !irq_o)
        else $error("interrupt raised during programming");
    a_rsv_zero: assert property ((rd_i && addr_i == 8'h37) |=> !rdata_o[5])
        else $error("unused bit read as one");
    a_unmapped_zero: assert property ((rd_i && addr_i != 8'h37) |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_write_halts: assert property (flash_write_o |-> stall_o)
        else $error("page write without halt");
    a_start_cause: assert property ((flash_write_o || flash_erase_o) |-> $past(spm_i))
        else $error("flash operation without store");
    a_stall_hold: assert property ($rose(stall_o) |-> stall_o [*6])
        else $error("halt dropped early");
    a_stall_bound: assert property (stall_cnt <= PROG_CYCLES + 1)
        else $error("halt lasts too long");
    a_lpm_cause: assert property (lpm_valid_o |-> $past(lpm_i))
        else $error("lock/fuse byte without load");
    a_fuse_low: assert property ((lpm_valid_o && $past(z_i[1:0]) == 2'h0)
        |-> lpm_data_o == $past(fuse_low_i))
        else $error("fuse low byte wrong");

    c_halt: cover property ($rose(stall_o));
    c_lpm: cover property (lpm_valid_o);
    c_irq: cover property (irq_o);
endmodule // fspc_ctrl_monitor

bind fspc_ctrl fspc_ctrl_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .spm_i(spm_i), .lpm_i(lpm_i), .z_i(z_i),
    .gie_i(gie_i), .eeprom_busy_i(eeprom_busy_i),
    .fuse_low_i(fuse_low_i), .lpm_valid_o(lpm_valid_o),
    .lpm_data_o(lpm_data_o), .stall_o(stall_o), .irq_o(irq_o),
    .flash_erase_o(flash_erase_o), .flash_write_o(flash_write_o)
);

`default_nettype wire

// >>> fspc_ctrl_test.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Self-checking bench
// ****************************************************************
module fspc_ctrl_test;
    logic mclk_i, rst_i, wr_i, rd_i, gie_i, eeprom_busy_i;
    logic [7:0] addr_i, wdata_i, fuse_low_i, fuse_high_i, fuse_ext_i;
    logic [5:0] lock_bits_i;
    logic [1:0] boot_size_fuses_i;
    logic [4:0] buf_rd_addr_i;
    logic [7:0] rdata_o, lpm_data_o;
    logic [15:0] buf_rd_data_o, z_i, r_word_i;
    logic lpm_valid_o, stall_o, rw_blocked_o, irq_o, spm_i, lpm_i;
    logic flash_erase_o, flash_write_o;
    logic [9:0] flash_page_o;
    logic [14:0] pc_i;
    int fails, n_checks, cyc;
    localparam logic [14:0] BOOT_PC = 15'h7C00;
    localparam logic [14:0] APP_PC = 15'h0100;
    logic [7:0] pats [5] = '{8'h01, 8'h03, 8'h05, 8'h09, 8'h11};
    logic [7:0] fuse_exp [4] = '{8'hA1, 8'hFE, 8'hC3, 8'hB2};

    fspc_ctrl #(.PROG_CYCLES(8)) dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .spm_i(spm_i), .lpm_i(lpm_i), .z_i(z_i), .r_word_i(r_word_i),
        .pc_i(pc_i), .gie_i(gie_i), .eeprom_busy_i(eeprom_busy_i),
        .lock_bits_i(lock_bits_i), .fuse_low_i(fuse_low_i),
        .fuse_high_i(fuse_high_i), .fuse_ext_i(fuse_ext_i),
        .boot_size_fuses_i(boot_size_fuses_i),
        .buf_rd_addr_i(buf_rd_addr_i), .buf_rd_data_o(buf_rd_data_o),
        .lpm_valid_o(lpm_valid_o), .lpm_data_o(lpm_data_o),
        .stall_o(stall_o), .rw_blocked_o(rw_blocked_o), .irq_o(irq_o),
        .flash_erase_o(flash_erase_o), .flash_write_o(flash_write_o),
        .flash_page_o(flash_page_o));

    fspc_cpu_model cpu (.mclk_i(mclk_i), .spm_o(spm_i), .lpm_o(lpm_i),
        .z_o(z_i), .r_word_o(r_word_i), .pc_o(pc_i));

    task automatic stop_test();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic flag(input string s, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %b seen %b", s, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= 8'h37;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 chk("register", {8'h00, e}, {8'h00, rdata_o});
    endtask

    task automatic bufw(input logic [4:0] i, input logic [15:0] e);
        @(posedge mclk_i);
        buf_rd_addr_i <= i;
        @(posedge mclk_i);
        #1 chk("buffer word", e, buf_rd_data_o);
    endtask

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            stop_test();
        end
    end

    initial begin
        {rst_i, wr_i, rd_i, gie_i, eeprom_busy_i} = 5'h10;
        {addr_i, wdata_i, boot_size_fuses_i, buf_rd_addr_i} = 23'h0;
        lock_bits_i = 6'h3E;
        {fuse_low_i, fuse_high_i, fuse_ext_i} = 24'hA1B2C3;
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(8'h37, 8'h00);
        rd(8'h20, 8'h00);
        bufw(5'h03, 16'hFFFF);
        // Fill at the last armed cycle with an odd Z.
        wr(8'h01);
        cpu.issue(1'b0, 16'h0007, 16'h1234, BOOT_PC, 3);
        rd(8'h37, 8'h00);
        bufw(5'h03, 16'h1234);
        wr(8'h01);
        cpu.issue(1'b0, 16'h0008, 16'hBEEF, BOOT_PC, 0);
        wr(8'h11);
        bufw(5'h03, 16'hFFFF);
        bufw(5'h04, 16'hFFFF);
        for (int k = 0; k < 5; k++) begin
            wr(pats[k]);
            rd(8'h37, pats[k]);
            repeat (6) @(posedge mclk_i);
        end
        wr(8'h07);
        rd(8'h37, 8'h00);
        // A store one cycle late finds the arm expired.
        for (int k = 1; k < 3; k++) begin
            wr(pats[k]);
            cpu.issue(1'b0, 16'hFA00, 16'h0000, BOOT_PC, 4);
            flag("late start", 1'b0, flash_write_o | flash_erase_o);
            rd(8'h37, 8'h00);
        end
        // Page write into the boot pages of the halting section.
        @(posedge mclk_i);
        gie_i <= 1'b1;
        wr(8'h85);
        cpu.issue(1'b0, 16'hFA00, 16'h5555, BOOT_PC, 1);
        flag("write start", 1'b1, flash_write_o);
        chk("page", 16'h03E8, {6'h00, flash_page_o});
        flag("halt", 1'b1, stall_o);
        flag("irq busy", 1'b0, irq_o);
        rd(8'h37, 8'h85);
        repeat (10) @(posedge mclk_i);
        rd(8'h37, 8'h80);
        flag("halt end", 1'b0, stall_o);
        flag("irq ready", 1'b1, irq_o);
        eeprom_busy_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        #1 flag("irq eeprom", 1'b0, irq_o);
        @(posedge mclk_i);
        eeprom_busy_i <= 1'b0;
        wr(8'h00);
        // Erase in the readable section leaves the core running.
        wr(8'h03);
        cpu.issue(1'b0, 16'h0140, 16'h0000, BOOT_PC, 0);
        flag("erase start", 1'b1, flash_erase_o);
        chk("page", 16'h0005, {6'h00, flash_page_o});
        flag("no halt", 1'b0, stall_o);
        repeat (10) @(posedge mclk_i);
        rd(8'h37, 8'h40);
        flag("blocked", 1'b1, rw_blocked_o);
        wr(8'h11);
        cpu.issue(1'b0, 16'h0000, 16'h0000, BOOT_PC, 0);
        rd(8'h37, 8'h00);
        flag("unblocked", 1'b0, rw_blocked_o);
        // App code, small boot section, boot write lock: all refused.
        for (int k = 0; k < 3; k++) begin
            @(posedge mclk_i);
            boot_size_fuses_i <= (k == 1) ? 2'h3 : 2'h0;
            lock_bits_i <= (k == 2) ? 6'h2E : 6'h3E;
            wr(8'h03);
            cpu.issue(1'b0, 16'hFA00, 16'h0000, (k == 0) ? APP_PC : BOOT_PC, 0);
            flag("refused", 1'b0, flash_erase_o | stall_o);
            rd(8'h37, 8'h00);
        end
        @(posedge mclk_i);
        {boot_size_fuses_i, lock_bits_i} <= 8'h3E;
        for (int k = 0; k < 4; k++) begin
            wr(8'h09);
            cpu.issue(1'b1, 16'(k), 16'h0000, BOOT_PC, k % 3);
            flag("lpm valid", 1'b1, lpm_valid_o);
            chk("lpm byte", {8'h00, fuse_exp[k]}, {8'h00, lpm_data_o});
        end
        wr(8'h09);
        cpu.issue(1'b1, 16'h0001, 16'h0000, BOOT_PC, 3);
        flag("late lpm", 1'b0, lpm_valid_o);
        stop_test();
    end
endmodule // fspc_ctrl_test

`default_nettype wire

// >>> fspc_params.svh
`ifndef FSPC_PARAMS_SVH
`define FSPC_PARAMS_SVH

// ****************************************************************
// Register map and field layout
// ****************************************************************
`define FSPC_REG_CSR 8'h37
`define FSPC_CSR_RESET 8'h00
`define FSPC_BIT_EN 0
`define FSPC_BIT_ERS 1
`define FSPC_BIT_WRT 2
`define FSPC_BIT_LFR 3
`define FSPC_BIT_RRE 4
`define FSPC_BIT_RSV 5
`define FSPC_BIT_BSY 6
`define FSPC_BIT_IE 7

// ****************************************************************
// Accepted command patterns in the lower five bits
// ****************************************************************
`define FSPC_PAT_FILL 5'h01
`define FSPC_PAT_ERS 5'h03
`define FSPC_PAT_WRT 5'h05
`define FSPC_PAT_LFR 5'h09
`define FSPC_PAT_RRE 5'h11

// ****************************************************************
// Timing
// ****************************************************************
`define FSPC_SPM_WINDOW 3'h4
`define FSPC_LPM_WINDOW 3'h3
`define FSPC_AGE_START 3'h1
`define FSPC_PROG_TIME_NS 3700000
`define FSPC_CLK_PERIOD_NS 100

// ****************************************************************
// Lock and fuse read selection, lock bit positions
// ****************************************************************
`define FSPC_ZSEL_FLO 2'h0
`define FSPC_ZSEL_LOCK 2'h1
`define FSPC_ZSEL_FEXT 2'h2
`define FSPC_ZSEL_FHI 2'h3
`define FSPC_BLB01 2
`define FSPC_BLB11 4
`define FSPC_ERASED_WORD 16'hFFFF

// ****************************************************************
// Boot section size in pages per boot_size_fuses code
// ****************************************************************
`define FSPC_BOOT_PG_0 32
`define FSPC_BOOT_PG_1 16
`define FSPC_BOOT_PG_2 8
`define FSPC_BOOT_PG_3 4
`define FSPC_BOOT_PG_MAX 32

`endif

// >>> fspc_pkg.sv
`default_nettype none

package fspc_pkg;

    // Sequencer states, one-hot.
    typedef enum logic [2:0] {
        FSPC_IDLE  = 3'b001,
        FSPC_ARMED = 3'b010,
        FSPC_BUSY  = 3'b100
    } fspc_state_t;

endpackage : fspc_pkg

`default_nettype wire
